// ==== rtl/async_line_store.sv ====
// Small memory of 4-bit asynchronous line registers, registered read.
// Assumes a synchronous active low reset; clr wipes every word.
`timescale 1ns/10ps
module async_line_store #(
    parameter int AW = 6,
    parameter int DW = 4
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    line_store_if.mem st
);
    logic [DW-1:0] mem_r [0:(1<<AW)-1];

    // ****************************************
    // Storage, cleared word by word on reset
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < (1 << AW); gi++) begin : g_word
            always_ff @(posedge sys_clk) begin
                if (!rst_n || st.clr) begin
                    mem_r[gi] <= '0; // RULE_02
                end else if (st.we && st.waddr == AW'(gi)) begin
                    mem_r[gi] <= st.wdata; // RULE_10
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st.rdata <= '0;
        end else begin
            st.rdata <= mem_r[st.raddr];
        end
    end
endmodule

// ==== rtl/line_control_bank.sv ====
// Line control word loading and receive interrupt character register.
// Assumes an Avalon-MM master on word addresses and a receiver engine
// feeding sync-found and character events on sys_clk.
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "line_ctrl_defines.svh"

// Operation
// RULE_01 - Strobe stores bit 10 as sync pattern A or B choice
// RULE_02 - Initialize clears stored sync choice and receiver enable settings
// RULE_03 - Bit 13 at strobe starts the selected line hunting for sync
// RULE_04 - Sync found sets that line's receiver-active flag
// RULE_05 - Host must strobe receiver enable one per line after initialize
// RULE_06 - Resync comes from the line state resync flag, not enable
// RULE_07 - Host stops a line: strobe enable zero, then set resync
// RULE_08 - Sync card: bit 13 per line, bits 9-12,14 per group
// RULE_09 - Strobe clears itself and may share the write with its data
// RULE_10 - Async card: four 4-bit registers per line chosen by bits 10-09
// RULE_11 - Async strobe loads selected register of selected line, self-clears
// RULE_12 - Read-only receive register holds character, line and reason
// RULE_13 - Initialize clears the receive interrupt register
// RULE_14 - Bits 0-7 hold the character right justified
// RULE_15 - Short parity characters put parity just above the top bit
// RULE_16 - Bits 8-11 hold the receiving line number
// RULE_17 - Bits 12-15 hold the four bit reason code
// RULE_18 - Master clear wipes receive register and line control bits 7-14
// RULE_19 - Receive register fields change together from one event
module line_control_bank
    import line_ctrl_pkg::*;
#(
    parameter int LINES = 16,
    parameter int ADDR_W = 4
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [LINES-1:0] sync_found,
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char,
    input wire logic [3:0] rx_char_bits,
    input wire logic rx_char_parity_en,
    input wire logic rx_char_parity,
    input wire logic [3:0] rx_line,
    input wire logic [3:0] rx_reason,
    output logic [LINES-1:0] rx_hunt,
    output logic [LINES-1:0] rx_resync,
    output logic [LINES-1:0] sync_pattern_b,
    output logic [LINES-1:0] async_card
);
    localparam int LW = $clog2(LINES);
    localparam int GROUPS = LINES / 4;

    // ****************************************
    // Elaboration checks
    // ****************************************
    // Line field and four-line groups are sized for 16 lines
    if (LINES != 16) begin : g_bad_lines
        $error("line_control_bank: LINES must be 16");
    end
    // Register map reaches word address 8
    if (ADDR_W < 4) begin : g_bad_addr
        $error("line_control_bank: ADDR_W must be at least 4");
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] place_parity(input logic [7:0] ch, input logic [3:0] nbits,
                                                input logic pen, input logic par);
        logic [7:0] r;
        r = ch;
        // Eight-bit characters leave no room, so parity is dropped
        if (pen && nbits < 4'h8) begin
            r[nbits[2:0]] = par;
        end
        return r;
    endfunction

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] reg_addr);
        return a == ADDR_W'(reg_addr);
    endfunction

    // ****************************************
    // State
    // ****************************************
    bus_state_t bus_r;
    logic [15:0] lcw_r;
    logic [15:0] ric_r;
    logic [15:0] ric_nxt;
    logic [3:0] ssel_r;
    logic [LINES-1:0] rx_en_r;
    logic [LINES-1:0] rx_active_r;
    logic [LINES-1:0] resync_r;
    logic [LINES-1:0] card_mode_r;
    logic [4:0] grp_bits_r [0:GROUPS-1];
    logic [15:0] rx_event_r;
    logic [31:0] rdata_nxt;
    logic wr_go;
    logic strobe_go;
    logic mclr_go;
    logic [15:0] wdata16;
    logic wr_lcw;
    logic wr_ssel;
    logic wr_lstate;
    logic wr_mode;
    logic [6:0] sync_view;

    line_store_if #(.AW(LW + 2), .DW(4)) st ();

    async_line_store #(.AW(LW + 2), .DW(4)) u_store (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .st(st)
    );

    assign wdata16 = avs_writedata[15:0];
    // Acts at the edge where waitrequest is seen low, once per held request
    assign wr_go = avs_write && bus_r == BUS_DONE;
    assign strobe_go = wr_lcw && wdata16[`LCW_STROBE];
    assign mclr_go = wr_go && hit(avs_address, `ADDR_SYSTEM_CONTROL) && wdata16[`SCW_MASTER_CLEAR];

    // ****************************************
    // Write decode, one enable per register
    // ****************************************
    assign wr_lcw = wr_go && hit(avs_address, `ADDR_LINE_CONTROL);
    assign wr_ssel = wr_go && hit(avs_address, `ADDR_SECONDARY_SELECT);
    assign wr_lstate = wr_go && hit(avs_address, `ADDR_LINE_STATE);
    assign wr_mode = wr_go && hit(avs_address, `ADDR_CARD_MODE);

    // ****************************************
    // Bus handshake: writes take one wait, reads two
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bus_r <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
        end else begin
            // DONE always returns to IDLE, so one request never acts twice
            case (bus_r)
                BUS_IDLE: begin
                    if (avs_write) begin
                        bus_r <= BUS_DONE;
                        avs_waitrequest <= 1'b0;
                    end else if (avs_read) begin
                        bus_r <= BUS_READ;
                    end
                end
                BUS_READ: begin
                    bus_r <= BUS_DONE;
                    avs_waitrequest <= 1'b0;
                end
                BUS_DONE: begin
                    bus_r <= BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default: begin
                    bus_r <= BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // ****************************************
    // Line control word and select
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            lcw_r <= `RST_WORD16;
        end else if (mclr_go) begin
            lcw_r[`LCW_CLR_HI:`LCW_CLR_LO] <= '0; // RULE_18
        end else if (wr_lcw) begin
            // Strobe never stored, so it reads back as zero
            lcw_r <= {1'b0, wdata16[14:0]}; // RULE_09
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ssel_r <= 4'h0;
        end else if (wr_ssel) begin
            ssel_r <= wdata16[3:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            card_mode_r <= '0;
        end else if (wr_mode) begin
            card_mode_r <= wdata16[LINES-1:0];
        end
    end

    // ****************************************
    // Synchronous card storage
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rx_en_r <= '0; // RULE_02
            sync_pattern_b <= '0; // RULE_02
        end else if (strobe_go && !card_mode_r[ssel_r]) begin
            rx_en_r[ssel_r] <= wdata16[`LCW_RX_ENABLE]; // RULE_03 RULE_08
            sync_pattern_b[ssel_r] <= wdata16[`LCW_SYNC_SEL]; // RULE_01
        end
    end

    genvar gg;
    generate
        for (gg = 0; gg < GROUPS; gg++) begin : g_grp
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    grp_bits_r[gg] <= '0;
                end else if (strobe_go && !card_mode_r[ssel_r] && ssel_r[3:2] == 2'(gg)) begin
                    grp_bits_r[gg] <= {wdata16[14], wdata16[12:9]}; // RULE_08
                end
            end
        end
    endgenerate

    // ****************************************
    // Asynchronous card registers
    // ****************************************
    assign st.we = strobe_go && card_mode_r[ssel_r]; // RULE_11
    assign st.waddr = {ssel_r, wdata16[`LCW_SYNC_SEL:`LCW_REGSEL_LO]}; // RULE_10
    assign st.wdata = wdata16[`LCW_RX_ENABLE+1:`LCW_ASYNC_LO];
    assign st.raddr = {ssel_r, lcw_r[`LCW_SYNC_SEL:`LCW_REGSEL_LO]};
    // Contents survive master clear; only reset wipes them
    assign st.clr = 1'b0;

    // ****************************************
    // Receiver state: hunt, active, resync
    // ****************************************
    // A sync found on an enabled line in the resync cycle wins: the line is in sync again
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rx_active_r <= '0;
        end else begin
            for (int i = 0; i < LINES; i++) begin
                if (sync_found[i] && rx_en_r[i]) begin
                    rx_active_r[i] <= 1'b1; // RULE_04
                end else if (resync_r[i]) begin
                    rx_active_r[i] <= 1'b0; // RULE_06 RULE_07
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            resync_r <= '0;
        end else begin
            for (int i = 0; i < LINES; i++) begin
                resync_r[i] <= wr_lstate && ssel_r == i[3:0] && wdata16[`LS_RESYNC]; // RULE_06
            end
        end
    end

    // ****************************************
    // Receiver outputs, each from its own flop
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rx_hunt <= '0;
        end else begin
            rx_hunt <= rx_en_r & ~rx_active_r; // RULE_03
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rx_resync <= '0;
        end else begin
            rx_resync <= resync_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            async_card <= '0;
        end else begin
            async_card <= card_mode_r;
        end
    end

    // ****************************************
    // Receive interrupt character register
    // ****************************************
    always_comb begin
        ric_nxt = ric_r;
        if (mclr_go) begin
            ric_nxt = `RST_WORD16; // RULE_18
        end else if (rx_char_valid) begin
            ric_nxt = {rx_reason, rx_line, // RULE_16 RULE_17 RULE_19
                       place_parity(rx_char, rx_char_bits, rx_char_parity_en, rx_char_parity)}; // RULE_14 RULE_15
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ric_r <= `RST_WORD16; // RULE_13
        end else begin
            ric_r <= ric_nxt; // RULE_12
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rx_event_r <= '0;
        end else if (rx_char_valid && !mclr_go) begin
            // Wraps silently; only software deltas are meaningful
            rx_event_r <= rx_event_r + 16'h0001;
        end
    end

    // ****************************************
    // Read mux, registered for the answer cycle
    // ****************************************
    // Group bits are shared by four lines; the view shows the selected line's group
    assign sync_view = {grp_bits_r[ssel_r[3:2]], sync_pattern_b[ssel_r], rx_en_r[ssel_r]};

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (avs_address)
            ADDR_W'(`ADDR_LINE_CONTROL): rdata_nxt[15:0] = lcw_r;
            ADDR_W'(`ADDR_RX_INT_CHAR): rdata_nxt[15:0] = ric_r;
            ADDR_W'(`ADDR_SECONDARY_SELECT): rdata_nxt[3:0] = ssel_r;
            ADDR_W'(`ADDR_RX_EVENT): rdata_nxt[15:0] = rx_event_r;
            ADDR_W'(`ADDR_LINE_STATE): rdata_nxt[1:0] = {resync_r[ssel_r], rx_active_r[ssel_r]};
            ADDR_W'(`ADDR_SYNC_VIEW): rdata_nxt[6:0] = sync_view;
            ADDR_W'(`ADDR_ASYNC_VIEW): rdata_nxt[3:0] = st.rdata;
            ADDR_W'(`ADDR_CARD_MODE): rdata_nxt[15:0] = card_mode_r;
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (bus_r == BUS_READ) begin
            avs_readdata <= rdata_nxt;
        end
    end
endmodule

// ==== rtl/line_ctrl_defines.svh ====
// Offsets, field positions, reset values for the line control block.
// Assumes inclusion by bare name from the rtl folder.
`ifndef LINE_CTRL_DEFINES_SVH
`define LINE_CTRL_DEFINES_SVH

// ****************************************
// Register word addresses (byte address / 4)
// ****************************************
`define ADDR_LINE_CONTROL 4'h0
`define ADDR_RX_INT_CHAR 4'h1
`define ADDR_SECONDARY_SELECT 4'h2
`define ADDR_SYSTEM_CONTROL 4'h3
`define ADDR_RX_EVENT 4'h4
`define ADDR_LINE_STATE 4'h5
`define ADDR_SYNC_VIEW 4'h6
`define ADDR_ASYNC_VIEW 4'h7
`define ADDR_CARD_MODE 4'h8

// ****************************************
// Line control word fields
// ****************************************
`define LCW_REGSEL_LO 9
`define LCW_SYNC_SEL 10
`define LCW_ASYNC_LO 11
`define LCW_RX_ENABLE 13
`define LCW_STROBE 15
`define LCW_CLR_LO 7
`define LCW_CLR_HI 14

// ****************************************
// System control word fields
// ****************************************
`define SCW_MASTER_CLEAR 11

// ****************************************
// Line state fields
// ****************************************
`define LS_RX_ACTIVE 0
`define LS_RESYNC 1

// ****************************************
// Reset values
// ****************************************
`define RST_WORD16 16'h0000

`endif

// ==== rtl/line_ctrl_pkg.sv ====
// Types shared by the line control block files.
// Assumes nothing beyond a SystemVerilog compiler.
package line_ctrl_pkg;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_READ = 2'b01,
        BUS_DONE = 2'b11
    } bus_state_t;

    typedef enum logic [1:0] {
        AREG_PRIMARY = 2'b00,
        AREG_FORMAT = 2'b01,
        AREG_BAUD = 2'b10,
        AREG_MAINT = 2'b11
    } async_reg_t;
endpackage

// ==== rtl/line_store_if.sv ====
// Write and read carrier between the register bank and its line store.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
interface line_store_if #(parameter int AW = 6, parameter int DW = 4);
    logic we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;
    logic clr;
    modport bank (output we, output waddr, output wdata, output raddr, output clr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, input clr, output rdata);
endinterface

// ==== sim/line_control_bank_bench.sv ====
// Self-checking bench for line_control_bank over Avalon-MM.
// Assumes the checker file is compiled too, for its bind.
`timescale 1ns/10ps
`include "line_ctrl_defines.svh"
module line_control_bank_bench;
    localparam logic [3:0] lcw = `ADDR_LINE_CONTROL;
    localparam logic [3:0] rx_interrupt_char_reg = `ADDR_RX_INT_CHAR;
    localparam logic [3:0] sel = `ADDR_SECONDARY_SELECT;
    localparam logic [3:0] lst = `ADDR_LINE_STATE;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] rd;
    logic [15:0] sync_found = 16'h0;
    logic rx_char_valid = 1'b0;
    logic rx_char_parity_en = 1'b0;
    logic rx_char_parity = 1'b0;
    logic [7:0] rx_char = 8'h0;
    logic [3:0] rx_char_bits = 4'h8;
    logic [3:0] rx_line = 4'h0;
    logic [3:0] rx_reason = 4'h0;
    logic resync_seen = 1'b0;
    wire [31:0] avs_readdata;
    wire avs_waitrequest;
    wire [15:0] rx_hunt;
    wire [15:0] rx_resync;
    wire [15:0] sync_pattern_b;
    wire [15:0] async_card;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;

    line_control_bank i_line_control_bank (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sync_found(sync_found),
        .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_char_bits(rx_char_bits),
        .rx_char_parity_en(rx_char_parity_en), .rx_char_parity(rx_char_parity), .rx_line(rx_line),
        .rx_reason(rx_reason), .rx_hunt(rx_hunt), .rx_resync(rx_resync),
        .sync_pattern_b(sync_pattern_b), .async_card(async_card));

    // ****************************************
    // Clock, watchdog, tasks
    // ****************************************
    always #50 sys_clk = ~sys_clk;

    // Pulse lasts one cycle, so keep a sticky copy
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (rx_resync[3])
            resync_seen <= 1'b1;
        if (cycles == 5000) begin
            miscompares = miscompares + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Waitrequest sampled at each rising edge; request dropped only after the one seen low
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= {16'h0, d};
        avs_write <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest);
        avs_write <= 1'b0;
    endtask

    task automatic rdc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge sys_clk);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest);
        rd = avs_readdata;
        avs_read <= 1'b0;
        chk(rd & {16'hffff, m}, {16'h0, e});
    endtask

    task automatic push(input logic [7:0] c, input logic [3:0] n, input logic p, input logic [7:0] lr);
        @(posedge sys_clk);
        {rx_char, rx_char_bits, rx_char_parity_en, rx_char_parity} <= {c, n, p, p};
        {rx_reason, rx_line} <= lr;
        rx_char_valid <= 1'b1;
        @(posedge sys_clk);
        rx_char_valid <= 1'b0;
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdc(lcw, 16'hffff, 16'h0);
        rdc(rx_interrupt_char_reg, 16'hffff, 16'h0);
        $display("test reset done");
        wr(sel, 16'h0003);
        wr(lcw, 16'hb600);
        repeat (2) @(negedge sys_clk);
        chk(rx_hunt, 16'h0008);
        chk(sync_pattern_b, 16'h0008);
        rdc(lcw, 16'hffff, 16'h3600);
        rdc(`ADDR_SYNC_VIEW, 16'h007f, 16'h002f);
        wr(sel, 16'h0001);
        rdc(`ADDR_SYNC_VIEW, 16'h007d, 16'h002c);
        wr(sel, 16'h0005);
        rdc(`ADDR_SYNC_VIEW, 16'h007d, 16'h0);
        wr(sel, 16'h0003);
        $display("test strobe done");
        @(posedge sys_clk);
        sync_found <= 16'h0008;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(rx_hunt, 16'h0);
        rdc(lst, 16'h0001, 16'h0001);
        wr(lcw, 16'h8000);
        rdc(lst, 16'h0001, 16'h0001);
        @(posedge sys_clk);
        sync_found <= 16'h0;
        wr(lst, 16'h0002);
        rdc(lst, 16'h0001, 16'h0);
        chk(resync_seen, 1'b1);
        $display("test sync line done");
        wr(`ADDR_CARD_MODE, 16'h0020);
        repeat (2) @(negedge sys_clk);
        chk(async_card, 16'h0020);
        wr(sel, 16'h0005);
        for (int k = 0; k < 4; k++)
            wr(lcw, 16'h8000 | 16'(k << 9) | 16'((k + 9) << 11));
        for (int k = 0; k < 4; k++) begin
            wr(lcw, 16'(k << 9));
            rdc(`ADDR_ASYNC_VIEW, 16'h000f, 16'(k + 9));
        end
        $display("test async done");
        push(8'hc3, 4'h8, 1'b0, 8'h59);
        rdc(rx_interrupt_char_reg, 16'hffff, 16'h59c3);
        push(8'h2a, 4'h7, 1'b1, 8'hf2);
        rdc(rx_interrupt_char_reg, 16'hffff, 16'hf2aa);
        push(8'h15, 4'h5, 1'b1, 8'h1f);
        rdc(rx_interrupt_char_reg, 16'hffff, 16'h1f35);
        rdc(`ADDR_RX_EVENT, 16'hffff, 16'h0003);
        wr(rx_interrupt_char_reg, 16'hffff);
        rdc(rx_interrupt_char_reg, 16'hffff, 16'h1f35);
        wr(4'hf, 16'hffff);
        rdc(4'hf, 16'hffff, 16'h0);
        $display("test receive char done");
        wr(lcw, 16'h7f80);
        rdc(lcw, 16'hffff, 16'h7f80);
        wr(`ADDR_SYSTEM_CONTROL, 16'h0800);
        rdc(lcw, 16'h7f80, 16'h0);
        rdc(rx_interrupt_char_reg, 16'hffff, 16'h0);
        rdc(`ADDR_SYSTEM_CONTROL, 16'h0800, 16'h0);
        $display("test master clear done");
        wr(sel, 16'h0003);
        wr(lcw, 16'ha400);
        push(8'h7e, 4'h8, 1'b0, 8'h33);
        @(negedge sys_clk);
        chk(rx_hunt, 16'h0008);
        rdc(rx_interrupt_char_reg, 16'hffff, 16'h337e);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        chk({rx_hunt, sync_pattern_b}, 32'h0);
        rdc(rx_interrupt_char_reg, 16'hffff, 16'h0);
        $display("test mid reset done");
        end_of_test();
    end
endmodule

// ==== sim/line_control_checker.sv ====
// Port assertions for line_control_bank.
// Assumes binding onto every instance, one clock, sync reset.
`timescale 1ns/10ps
`include "line_ctrl_defines.svh"
module line_control_checker #(
    parameter int LINES = 16,
    parameter int ADDR_W = 4
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [LINES-1:0] sync_found,
    input wire logic [LINES-1:0] rx_hunt,
    input wire logic [LINES-1:0] rx_resync,
    input wire logic [LINES-1:0] sync_pattern_b
);
    // ****************************************
    // Write causes
    // ****************************************
    wire strobe_wr = avs_write && avs_address == `ADDR_LINE_CONTROL && avs_writedata[`LCW_STROBE];
    wire resync_wr = avs_write && avs_address == `ADDR_LINE_STATE && avs_writedata[`LS_RESYNC];
    wire mclr_wr = avs_write && avs_address == `ADDR_SYSTEM_CONTROL && avs_writedata[`SCW_MASTER_CLEAR];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Depth 2 allowed: output may lag by one register stage
    AST_INIT_CLEAR: assert property ($rose(rst_n) |-> rx_hunt == 0 && sync_pattern_b == 0)
        else $error("outputs not cleared by reset");
    AST_HUNT_CAUSE: assert property ((rx_hunt & ~$past(rx_hunt)) != 0 |->
        $past(strobe_wr) || $past(strobe_wr, 2) || $past(resync_wr, 2)) else $error("hunt rose uncaused");
    AST_HUNT_END: assert property ((rx_hunt & sync_found) != 0 ##1 (rx_hunt & sync_found) != 0
        |=> (rx_hunt & sync_found) == 0) else $error("hunt kept after sync");
    AST_SYNC_SEL_CAUSE: assert property (sync_pattern_b != $past(sync_pattern_b) |->
        $past(strobe_wr) || $past(strobe_wr, 2) || $past(mclr_wr, 2)) else $error("sync choice moved");
    AST_RESYNC_CAUSE: assert property (rx_resync != 0 |->
        $past(resync_wr) || $past(resync_wr, 2)) else $error("resync without request");
    AST_RESYNC_PULSE: assert property (rx_resync != 0 |=> rx_resync == 0)
        else $error("resync longer than a cycle");
    AST_STROBE_READS_ZERO: assert property (avs_read && !avs_waitrequest &&
        avs_address == `ADDR_LINE_CONTROL |-> !avs_readdata[`LCW_STROBE]) else $error("strobe not cleared");
    AST_WRITE_ACK: assert property ($rose(avs_write) |=> !avs_waitrequest)
        else $error("write answer late");
    AST_READ_ACK: assert property ($rose(avs_read) |=> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read answer timing");
endmodule

bind line_control_bank line_control_checker #(.LINES(LINES), .ADDR_W(ADDR_W)) i_line_control_checker (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sync_found(sync_found), .rx_hunt(rx_hunt),
    .rx_resync(rx_resync), .sync_pattern_b(sync_pattern_b));
